//--- rtl/timer_capture_modes.sv
`timescale 1ns/100ps
`default_nettype none
module timer_capture_modes
  import tcap_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_in,  // external timer input pin
  output logic             timer_out, // pwm output
  output logic             irq        // level timer interrupt
);

  // ************************************************************
  // declarations
  // ************************************************************
  // the block state apart from the prescaler divider lives in cur, so every output is a flop field
  // the counter is 16 bits and wraps through reload only, so a reload
  // below the present count first runs the full 16-bit range;
  // a software count write is the way out of that long wrap
  tstate_t    cur;       // all registered state
  tstate_t    next_cur;  // next value of that state
  logic       tick;      // prescaled count enable
  tmode_t     mode;      // decoded mode
  logic       sel_edge;  // selected edge seen this clock
  logic       do_wr;     // apb write completes
  logic       setup;     // apb setup cycle
  logic       mapped;    // address hits a register
  logic       cap_ev;    // capture event
  logic       rld_ev;    // reload / compare event
  logic       cap_irq;   // capture allowed to interrupt
  logic       rld_irq;   // reload allowed to interrupt
  logic       run;       // timer enabled

  // ************************************************************
  // prescaler
  // ************************************************************
  // divider runs only while enabled, so every start of the timer
  // begins with a full prescale period before the first count
  tcap_prescaler u_prescaler (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (run),
    .prescale (cur.ctrl.prescale),
    .tick     (tick)
  );

  // ************************************************************
  // next state
  // ************************************************************
  // order matters below: timer events first, then the cause flag,
  // then the bus, so a software write to count or pwm in the same
  // clock beats the hardware update; status is handled last so that
  // a hardware set still beats a software clear
  always_comb begin
    next_cur = cur;
    run      = cur.ctrl.enable;
    mode     = tmode_t'({cur.ctrl2.mode_high_bit, cur.ctrl.mode_lo});
    setup    = psel && !penable;
    do_wr    = psel && penable && pwrite && cur.pready;
    mapped   = 1'b0;
    // events default to none; the mode branches below raise them
    cap_ev   = 1'b0;
    rld_ev   = 1'b0;
    next_cur.tin_prev = timer_in;

    // edge choice: polarity 1 rising, 0 falling
    // the pin is synchronous, so one stored level is enough; it resets
    // low like the idle pin, so no false edge follows reset
    if (cur.ctrl.input_polarity_bit) begin
      sel_edge = timer_in && !cur.tin_prev;
    end else begin
      sel_edge = !timer_in && cur.tin_prev;
    end

    // ---- counting and capture, only while enabled ----
    if (run) begin
      case (mode)
        mode_capture: begin
          // capture on edge, counter not disturbed
          if (sel_edge) begin
            next_cur.pwm = cur.count;
            cap_ev = 1'b1;
          end
          // a reload match wraps to 0001 like the other modes
          if (tick) begin
            if (cur.count == cur.reload) begin
              next_cur.count = restart_val; // keeps counting
              rld_ev = 1'b1;
            end else begin
              next_cur.count = cur.count + 16'h0001;
            end
          end
        end
        mode_cap_restart: begin
          // capture wins over a compare in the same clock
          // the prescaler is not restarted by a capture, so the first
          // period after a restart may be short by up to one prescale
          // a compare match without capture restarts and clears the cause
          if (sel_edge) begin
            next_cur.pwm   = cur.count;
            next_cur.count = restart_val;
            cap_ev = 1'b1;
          end else if (tick) begin
            if (cur.count == cur.reload) begin
              next_cur.count = restart_val;
              rld_ev = 1'b1;
            end else begin
              next_cur.count = cur.count + 16'h0001;
            end
          end
        end
        mode_cap_compare: begin
          if (!cur.started) begin
            // idle until the first selected edge; that edge only arms,
            // it stores no count and raises nothing
            // ticks keep their phase from the enable, not from this edge
            if (sel_edge) begin
              next_cur.started = 1'b1;
            end
          end else if (sel_edge) begin
            // every later edge captures and restarts
            next_cur.pwm   = cur.count;
            next_cur.count = restart_val;
            cap_ev = 1'b1;
          end else if (tick) begin
            if (cur.count == cur.reload) begin
              next_cur.count = restart_val;
              rld_ev = 1'b1;
            end else begin
              next_cur.count = cur.count + 16'h0001;
            end
          end
        end
        default: begin
          // continuous and pwm: count 1..reload and wrap
          // unused mode codes land here as well
          if (tick) begin
            if (cur.count == cur.reload) begin
              next_cur.count = restart_val;
              rld_ev = 1'b1;
            end else begin
              next_cur.count = cur.count + 16'h0001;
            end
          end
        end
      endcase
    end else begin
      // while stopped nothing counts, captures or interrupts
      // re-arm capture/compare for the next start
      next_cur.started = 1'b0;
    end

    // ---- cause flag: capture sets, reload clears ----
    // only the capture modes keep a cause; pwm and continuous leave it
    // a capture in the same clock as a reload keeps the flag set
    if (cap_ev) begin
      next_cur.ctrl2.capture_cause_flag = 1'b1;
    end else if (rld_ev && (mode != mode_continuous) && (mode != mode_pwm)) begin
      next_cur.ctrl2.capture_cause_flag = 1'b0;
    end

    // ---- interrupt source gating ----
    // the cause flag above ignores this gate on purpose
    // source select value 3 behaves as both
    cap_irq = cap_ev && (cur.ctrl2.interrupt_source_select != isel_reload);
    rld_irq = rld_ev && (cur.ctrl2.interrupt_source_select != isel_capture);

    // ---- pwm output, count runs 1..reload ----
    // registered compare, so the pin trails the count by one clock
    // high fraction: pwm/reload, or (reload-pwm)/reload when inverted
    if (!run) begin
      // a stopped timer holds the pin low
      next_cur.timer_out = 1'b0;
    end else if (cur.ctrl.input_polarity_bit) begin
      next_cur.timer_out = (cur.count <= cur.pwm); // pwm/reload high
    end else begin
      next_cur.timer_out = (cur.count > cur.pwm);  // (reload-pwm)/reload
    end

    // ---- apb read mux, sampled in setup ----
    // zero wait states: setup is decoded here and the answer stands
    // for exactly the access cycle; data is taken at setup so it
    // cannot move under the master while pready is high
    next_cur.pready  = setup;
    next_cur.pslverr = 1'b0;
    if (setup) begin
      mapped = 1'b1;
      case (paddr)
        ctrl_addr:   next_cur.prdata = {24'h000000, cur.ctrl.prescale,
                       cur.ctrl.input_polarity_bit, cur.ctrl.mode_lo, cur.ctrl.enable};
        ctrl2_addr:  next_cur.prdata = {28'h0000000, cur.ctrl2.capture_cause_flag,
                       cur.ctrl2.interrupt_source_select, cur.ctrl2.mode_high_bit};
        count_addr:  next_cur.prdata = {16'h0000, cur.count};
        reload_addr: next_cur.prdata = {16'h0000, cur.reload};
        pwm_addr:    next_cur.prdata = {16'h0000, cur.pwm};
        stat_addr:   next_cur.prdata = {30'h00000000, cur.stat};
        clr_addr:    next_cur.prdata = unmapped_rdata; // write only
        ien_addr:    next_cur.prdata = {30'h00000000, cur.ien};
        // unmapped offsets answer zero with the error flag
        default: begin
          mapped = 1'b0;
          next_cur.prdata = unmapped_rdata;
        end
      endcase
      next_cur.pslverr = !mapped;
    end

    // ---- apb writes at the access edge ----
    // software write to count or pwm overrides the hardware update
    if (do_wr) begin
      case (paddr)
        ctrl_addr: begin
          // fields placed by their package positions
          next_cur.ctrl.enable             = pwdata[ctrl_en_bit];
          next_cur.ctrl.mode_lo            = pwdata[ctrl_mode_lsb +: 3];
          next_cur.ctrl.input_polarity_bit = pwdata[ctrl_pol_bit];
          next_cur.ctrl.prescale           = pwdata[ctrl_pres_lsb +: 3];
        end
        ctrl2_addr: begin
          // the cause flag is read only and is not written here
          next_cur.ctrl2.mode_high_bit           = pwdata[ctrl2_mhi_bit];
          next_cur.ctrl2.interrupt_source_select = pwdata[ctrl2_isel_lsb +: 2];
        end
        count_addr:  next_cur.count  = pwdata[15:0];
        reload_addr: next_cur.reload = pwdata[15:0];
        pwm_addr:    next_cur.pwm    = pwdata[15:0];
        ien_addr:    next_cur.ien    = pwdata[1:0];
        // status, clear and unmapped offsets store nothing here
        default: begin
          next_cur.prdata = cur.prdata;
        end
      endcase
    end

    // ---- sticky status: set wins over clear ----
    // the clear register is write one to clear; an event in the same
    // clock as its clear survives, so no clear loses an event that the source select passes
    if (do_wr && (paddr == clr_addr)) begin
      next_cur.stat = cur.stat & ~pwdata[1:0];
    end
    if (cap_irq || rld_irq) begin
      next_cur.stat[stat_tmr_bit] = 1'b1;
    end
    if (cap_irq) begin
      next_cur.stat[stat_cap_bit] = 1'b1;
    end

    // level interrupt from the next status
    // so irq rises on the same edge as the status bit
    next_cur.irq = |(next_cur.stat & next_cur.ien);
  end

  // ************************************************************
  // state register
  // ************************************************************
  // reset loads constants only; reload and the data registers have
  // their own reset values, hence the extra lines after the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur        <= '0;
      cur.count  <= count_rst;
      cur.reload <= reload_rst;
      cur.pwm    <= pwm_rst;
    end else begin
      cur <= next_cur;
    end
  end

  // ************************************************************
  // outputs straight from flops
  // ************************************************************
  // plain renames of flop fields, no logic on the way out
  assign prdata    = cur.prdata;
  assign pready    = cur.pready;
  assign pslverr   = cur.pslverr;
  assign timer_out = cur.timer_out;
  assign irq       = cur.irq;

endmodule
`default_nettype wire

//--- rtl/tcap_pkg.sv
package tcap_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] ctrl_addr   = 8'h00; // enable, mode, polarity, prescale
  localparam logic [7:0] ctrl2_addr  = 8'h04; // mode high bit, int source, cause flag
  localparam logic [7:0] count_addr  = 8'h08; // live counter
  localparam logic [7:0] reload_addr = 8'h0c; // reload / compare value
  localparam logic [7:0] pwm_addr    = 8'h10; // pwm value / captured count
  localparam logic [7:0] stat_addr   = 8'h14; // sticky events, read only
  localparam logic [7:0] clr_addr    = 8'h18; // write one to clear, write only
  localparam logic [7:0] ien_addr    = 8'h1c; // interrupt enable

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int ctrl_en_bit    = 0;
  localparam int ctrl_mode_lsb  = 1; // three bits
  localparam int ctrl_pol_bit   = 4;
  localparam int ctrl_pres_lsb  = 5; // three bits, divide by 2**n
  localparam int ctrl2_mhi_bit  = 0;
  localparam int ctrl2_isel_lsb = 1; // two bits
  localparam int ctrl2_cause_bit = 3;
  localparam int stat_tmr_bit   = 0; // timer interrupt event
  localparam int stat_cap_bit   = 1; // capture event

  // ************************************************************
  // reset values and constants
  // ************************************************************
  localparam logic [15:0] count_rst  = 16'h0000;
  localparam logic [15:0] reload_rst = 16'hffff;
  localparam logic [15:0] pwm_rst    = 16'h0000;
  localparam logic [15:0] restart_val = 16'h0001;
  localparam logic [31:0] unmapped_rdata = 32'h0000_0000;

  // ************************************************************
  // modes: {mode_high_bit, three low mode bits}
  // ************************************************************
  typedef enum logic [3:0] {
    mode_continuous  = 4'b0001,
    mode_pwm         = 4'b0011,
    mode_capture     = 4'b0100,
    mode_cap_compare = 4'b0111,
    mode_cap_restart = 4'b1000
  } tmode_t;

  // interrupt source select
  localparam logic [1:0] isel_both    = 2'h0;
  localparam logic [1:0] isel_capture = 2'h1;
  localparam logic [1:0] isel_reload  = 2'h2;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic        enable;
    logic [2:0]  mode_lo;
    logic        input_polarity_bit;
    logic [2:0]  prescale;
  } ctrl_t;

  typedef struct packed {
    logic        mode_high_bit;
    logic [1:0]  interrupt_source_select;
    logic        capture_cause_flag;
  } ctrl2_t;

  typedef struct packed {
    ctrl_t       ctrl;
    ctrl2_t      ctrl2;
    logic [15:0] count;
    logic [15:0] reload;
    logic [15:0] pwm;
    logic [1:0]  stat;
    logic [1:0]  ien;
    logic        started;  // capture/compare armed by first edge
    logic        tin_prev; // previous timer input level
    logic        irq;
    logic        timer_out;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tstate_t;

endpackage

//--- rtl/tcap_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module tcap_prescaler
  import tcap_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,      // timer enable
  input  wire logic [2:0] prescale, // divide by 2**prescale
  output logic            tick      // one pulse per prescaled period
);

  // ************************************************************
  // gated divider
  // ************************************************************
  logic [6:0] div;      // running divider
  logic [6:0] div_mask; // low bits that must be all ones

  // mask grows with prescale; zero mask ticks every clock
  always_comb begin
    div_mask = 7'((8'h01 << prescale) - 8'h01);
  end

  // held clear while stopped so each start has a full first period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 7'h00;
    end else if (!run) begin
      div <= 7'h00;
    end else begin
      div <= div + 7'h01;
    end
  end

  // tick when the masked bits have all filled
  assign tick = run && ((div & div_mask) == div_mask);

endmodule
`default_nettype wire

//--- test/tcap_props.sv
`timescale 1ns/100ps
`default_nettype none
module tcap_props
  import tcap_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer_in,
  input wire logic        timer_out,
  input wire logic        irq
);
  // ****************************************
  // helper: completed write, enable shadow
  // ****************************************
  logic wr_hit; // write accepted this cycle
  logic en_h;   // enable as software last wrote it
  assign wr_hit = psel && penable && pready && pwrite;
  // shadow lets us judge irq without seeing inside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_h <= 1'b0;
    end else if (wr_hit && paddr == ctrl_addr) begin
      en_h <= pwdata[ctrl_en_bit];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (psel && !penable && paddr > 8'h1c
    |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  clr_reads_zero_a: assert property (psel && !penable && !pwrite && paddr == clr_addr
    |=> prdata == 32'h0) else $error("clear register read nonzero");
  irq_drop_cause_a: assert property ($fell(irq) |-> $past(wr_hit) || $past(wr_hit, 2))
    else $error("irq dropped without software write");
  idle_irq_a: assert property ($rose(irq) |-> $past(wr_hit) || $past(en_h) || $past(en_h, 2))
    else $error("irq raised while timer disabled");
  cover property (psel && penable && pready && pslverr);
  cover property ($rose(irq));
  cover property ($fell(irq));
endmodule
`default_nettype wire

//--- test/tin_model.sv
`timescale 1ns/100ps
`default_nettype none
// external source on the timer input pin
module tin_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic want,     // level the bench asks for
  output logic      timer_in  // pin level, synchronous to pclk
);
  // pin is routed to the timer function for the whole run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_in <= 1'b0;
    end else begin
      timer_in <= want;
    end
  end
endmodule
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import tcap_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, want = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, timer_in, timer_out, irq;
  logic [31:0] expq[$]; // expected read data, oldest first
  logic [15:0] rel;
  int          n_fail = 0, comparisons = 0, cyc = 0, t0 = 0;
  always #50 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  timer_capture_modes u_timer_capture_modes (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_in(timer_in), .timer_out(timer_out), .irq(irq));
  tin_model u_tin_model (.pclk(pclk), .presetn(presetn), .want(want), .timer_in(timer_in));
  // ****************************************
  // checking and closing
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("mismatches=%0d comparisons=%0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // read monitor: each answered read takes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk(prdata, expq.pop_front());
    end
  end
  // apb master, one idle edge first so no signal is set twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (i >= 16) begin
      n_fail++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_to(input int n);
    while (cyc < t0 + n) @(posedge pclk);
  endtask
  // reset, then set up a mode with the timer held off
  task automatic cfg(input tmode_t m, input logic pol, input logic [15:0] r, input logic [1:0] s);
    presetn <= 1'b0;
    want <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    wr(ctrl_addr, {24'h0, 3'h7, pol, m[2:0], 1'b0});
    wr(ctrl2_addr, {28'h0, s, m[3]});
    wr(count_addr, 32'h1);
    wr(reload_addr, {16'h0, r});
    wr(pwm_addr, 32'h0);
    wr(ien_addr, 32'h3);
    t0 = cyc;
  endtask
  task automatic go(input tmode_t m, input logic pol);
    wr(ctrl_addr, {24'h0, 3'h7, pol, m[2:0], 1'b1});
    t0 = cyc;
  endtask
  // ****************************************
  // scenarios, prescale 128: tick k at 128*k
  // ****************************************
  initial begin
    int k;
    k = $urandom(32'h154e2376);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(reload_addr, 32'hffff);
    rd(count_addr, 32'h0);
    rd(8'h20, unmapped_rdata);
    for (k = 0; k < 3; k++) begin
      rel = 16'($urandom()) | 16'h8000;
      cfg(mode_capture, 1'b1, rel, 2'(k));
      rd(reload_addr, {16'h0, rel});
      go(mode_capture, 1'b1);
      wait_to(5 * 128 + 64);
      want <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(irq, 32'(k != 2));
      rd(pwm_addr, 32'h6);
      rd(ctrl2_addr, {28'h0, 1'b1, 2'(k), 1'b0});
      wait_to(8 * 128 + 64);
      rd(count_addr, 32'h9);
      wr(ien_addr, 32'h0);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      wr(clr_addr, 32'h3);
      rd(stat_addr, 32'h0);
    end
    // falling edge selected, rising one ignored
    cfg(mode_capture, 1'b0, 16'hffff, isel_both);
    go(mode_capture, 1'b0);
    wait_to(2 * 128 + 64);
    want <= 1'b1;
    wait_to(4 * 128 + 64);
    want <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(pwm_addr, 32'h5);
    // restart: capture at count 2, then compare match at 3
    cfg(mode_cap_restart, 1'b1, 16'h0003, isel_both);
    go(mode_cap_restart, 1'b1);
    wait_to(128 + 64);
    want <= 1'b1;
    wait_to(2 * 128 + 64);
    rd(count_addr, 32'h2);
    rd(pwm_addr, 32'h2);
    rd(ctrl2_addr, 32'h9);
    wait_to(5 * 128 + 64);
    rd(ctrl2_addr, 32'h1);
    // edges placed off both possible prescaler phases
    cfg(mode_cap_compare, 1'b1, 16'hffff, isel_both);
    go(mode_cap_compare, 1'b1);
    wait_to(3 * 128 + 64);
    rd(count_addr, 32'h1);
    wait_to(4 * 128 + 32);
    want <= 1'b1;
    wait_to(5 * 128 + 64);
    chk(irq, 1'b0);
    want <= 1'b0;
    wait_to(7 * 128 + 80);
    want <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(irq, 1'b1);
    rd(pwm_addr, 32'h4);
    rd(count_addr, 32'h1);
    // pwm: reload 4, pwm 2, count 1..4, half of each period high
    for (k = 0; k < 2; k++) begin
      cfg(mode_pwm, 1'(k), 16'h0004, isel_both);
      wr(pwm_addr, 32'h2);
      go(mode_pwm, 1'(k));
      wait_to(64);
      chk(timer_out, 32'(k));
      wait_to(3 * 128 + 64);
      chk(timer_out, 32'(k == 0));
    end
    // timer left disabled: edges change nothing
    cfg(mode_capture, 1'b1, 16'hffff, isel_both);
    wait_to(300);
    want <= 1'b1;
    wait_to(600);
    chk(irq, 1'b0);
    rd(pwm_addr, 32'h0);
    rd(count_addr, 32'h1);
    wrap_up();
  end
endmodule
bind timer_capture_modes tcap_props u_tcap_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_in(timer_in),
  .timer_out(timer_out), .irq(irq));
`default_nettype wire
